/* File: adc_seq_pkg.sv */
// constants shared by the routine sequence controller
package adc_seq_pkg;
   localparam int CHAN_W = 5;
   localparam int DATA_W = 12;
   localparam int SEQ_MAX = 16;
   localparam int SEQ_IDX_W = 4;
   localparam int SMP_W = 3;
   localparam int CONV_HALF_CYCLES = 25;
   localparam logic [2:0] SRC_SOFTWARE = 3'h7;
   localparam logic [4:0] CH_TEMP = 5'h10;
   localparam logic [4:0] CH_VREF = 5'h11;
   localparam logic [4:0] CH_BATT = 5'h12;
   localparam logic [1:0] RES_12 = 2'h0;
   localparam logic [1:0] RES_10 = 2'h1;
   localparam logic [1:0] RES_8 = 2'h2;
   localparam logic [1:0] RES_6 = 2'h3;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam int CLK_PERIOD_NS = 40;
endpackage : adc_seq_pkg

/* File: adc_skid_buffer.sv */
// two-entry buffer between the result path and the dma side
`timescale 1ns/1ps
`default_nettype none
module adc_skid_buffer #(
   parameter int WIDTH = 16
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   logic [WIDTH-1:0] slot0_ff, slot1_ff, nxt_slot0, nxt_slot1;
   logic [1:0] count_ff, nxt_count;
   logic pushEn, popEn;
   logic outValid_ff, nxt_outValid;

   assign pushEn = inValid && (count_ff != 2'h2);
   assign popEn = outReady && (count_ff != 2'h0);
   assign inReady = (count_ff != 2'h2);
   assign outValid = outValid_ff;
   assign outData = slot0_ff;

   always_comb
   begin
      nxt_slot0 = slot0_ff;
      nxt_slot1 = slot1_ff;
      nxt_count = count_ff;
      if (popEn)
      begin
         nxt_slot0 = slot1_ff;
      end
      if (pushEn)
      begin
         if ((count_ff == 2'h0) || (count_ff == 2'h1 && popEn))
            nxt_slot0 = inData;
         else
            nxt_slot1 = inData;
      end
      if (pushEn && !popEn)
         nxt_count = count_ff + 2'h1;
      else if (popEn && !pushEn)
         nxt_count = count_ff - 2'h1;
      nxt_outValid = (nxt_count != 2'h0);
   end

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         slot0_ff <= '0;
         slot1_ff <= '0;
         count_ff <= 2'h0;
         outValid_ff <= 1'b0;
      end
      else
      begin
         slot0_ff <= nxt_slot0;
         slot1_ff <= nxt_slot1;
         count_ff <= nxt_count;
         outValid_ff <= nxt_outValid;
      end
   end
endmodule : adc_skid_buffer
`default_nettype wire

/* File: adc_routine_sequence_control.sv */
// routine sequence control: chunked mode, threshold monitor, justify, triggers, dma
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - with chunked mode on, each trigger converts a chunk of at most 8 channels
// - chunk length is the 3-bit field plus one
// - each trigger continues with the next channels until the sequence is done
// - end-of-sequence flag sets only after the whole sequence, not per chunk
// - interrupt on end of sequence or threshold event, each separately enabled
// - end-of-sequence flag clears when software writes zero to it
// - with monitor enabled, results outside the thresholds set the event flag
// - an upper and a lower threshold bound the allowed window
// - thresholds compare against the raw result before justification
// - monitored channels chosen by enable, single-channel bit and channel number
// - single bit set checks only the named channel, else all channels
// - stored result placement follows the justify select bit
// - left justify: 12/10/8-bit in a half-word, 6-bit in a byte
// - each channel has its own 3-bit sample-time selection
// - one channel takes sample time plus 12.5 converter clock cycles; the code rounds each up to whole clocks and adds one store clock
// - hardware trigger starts on the rising edge of the selected input
// - trigger source select maps codes 0 to 7 to the listed sources
// - with dma on, one request after every routine channel conversion
// - temp/ref enable makes channels 16 and 17 convertible
// - clearing temp/ref enable powers the temperature sensor down
// - battery enable makes channel 18 convertible and turns on the divider
module adc_routine_sequence_control #(
   parameter int SEQ_LEN_MAX = adc_seq_pkg::SEQ_MAX
) (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic converter_power_on,
   input wire logic scan_mode_enable,
   input wire logic chunked_mode_enable,
   input wire logic [2:0] chunk_length_minus_one,
   input wire logic [3:0] sequenceLengthMinusOne,
   input wire logic [SEQ_LEN_MAX*5-1:0] sequence_list_regs,
   input wire logic [19*3-1:0] sample_time_regs,
   input wire logic external_trigger_enable,
   input wire logic [2:0] trigger_source_select,
   input wire logic software_start_bit,
   input wire logic timer_a_ch0_event,
   input wire logic timer_a_ch1_event,
   input wire logic timer_a_ch2_event,
   input wire logic timer_b_ch1_event,
   input wire logic timer_c_trigger_out,
   input wire logic timer_d_ch0_event,
   input wire logic ext_line_eleven,
   input wire logic routine_monitor_enable,
   input wire logic monitor_single_channel,
   input wire logic [4:0] monitor_channel_number,
   input wire logic [11:0] upper_threshold,
   input wire logic [11:0] lower_threshold,
   input wire logic result_justify_select,
   input wire logic [1:0] resolutionSelect,
   input wire logic [11:0] rawResult,
   input wire logic dmaEnable,
   input wire logic dmaReady,
   input wire logic sequence_done_irq_enable,
   input wire logic threshold_event_irq_enable,
   input wire logic seqDoneClear,
   input wire logic thresholdEventClear,
   input wire logic temp_ref_channel_enable,
   input wire logic battery_channel_enable,
   output logic sequenceDone_ff,
   output logic threshold_event_flag,
   output logic irq_ff,
   output logic [15:0] resultData_ff,
   output logic dmaRequest,
   output logic [15:0] dmaData,
   output logic [4:0] convChannel_ff,
   output logic sampling_ff,
   output logic busy_ff,
   output logic tempSensorPowered_ff,
   output logic batteryDividerOn_ff
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_CONVERT = 2'b10,
      ST_STORE = 2'b11
   } state_t;

   state_t state_ff, nxt_state;
   logic [3:0] seqIdx_ff, nxt_seqIdx;
   logic [3:0] chunkLeft_ff, nxt_chunkLeft;
   logic [8:0] cycCnt_ff, nxt_cycCnt;
   logic [4:0] nxt_convChannel;
   logic nxt_sampling, nxt_busy, nxt_sequenceDone, nxt_threshold, nxt_irq;
   logic [15:0] nxt_resultData;
   logic trigSel, trigPrev_ff, trigger;
   logic [4:0] curChan;
   logic [2:0] smpSel;
   logic [8:0] smpHalf;
   logic outOfWindow, monitored, lastInSeq, chanAllowed;
   logic thrFlag_ff;
   logic bufValid, bufReady;
   logic [15:0] justified;

   assign threshold_event_flag = thrFlag_ff;

   // source selection, edge detected
   always_comb
   begin
      case (trigger_source_select)
         3'h0: trigSel = timer_a_ch0_event;
         3'h1: trigSel = timer_a_ch1_event;
         3'h2: trigSel = timer_a_ch2_event;
         3'h3: trigSel = timer_b_ch1_event;
         3'h4: trigSel = timer_c_trigger_out;
         3'h5: trigSel = timer_d_ch0_event;
         3'h6: trigSel = ext_line_eleven;
         default: trigSel = 1'b0;
      endcase
   end

   assign trigger = converter_power_on && (
      (trigger_source_select == adc_seq_pkg::SRC_SOFTWARE && software_start_bit) ||
      (trigger_source_select != adc_seq_pkg::SRC_SOFTWARE && external_trigger_enable
       && trigSel && !trigPrev_ff));

   assign curChan = sequence_list_regs[seqIdx_ff*5 +: 5];
   assign smpSel = (convChannel_ff < 5'd19) ? sample_time_regs[convChannel_ff*3 +: 3] : 3'h0;

   // sample cycles 1.5,7.5,13.5,28.5,41.5,55.5,71.5,239.5 in half cycles
   always_comb
   begin
      case (smpSel)
         3'h0: smpHalf = 9'h003;
         3'h1: smpHalf = 9'h00f;
         3'h2: smpHalf = 9'h01b;
         3'h3: smpHalf = 9'h039;
         3'h4: smpHalf = 9'h053;
         3'h5: smpHalf = 9'h06f;
         3'h6: smpHalf = 9'h08f;
         default: smpHalf = 9'h1df;
      endcase
   end

   assign chanAllowed = (curChan < adc_seq_pkg::CH_TEMP) ||
      (temp_ref_channel_enable && (curChan == adc_seq_pkg::CH_TEMP ||
       curChan == adc_seq_pkg::CH_VREF)) ||
      (battery_channel_enable && curChan == adc_seq_pkg::CH_BATT);
   assign lastInSeq = (seqIdx_ff == sequenceLengthMinusOne);
   assign outOfWindow = (rawResult > upper_threshold) || (rawResult < lower_threshold);
   assign monitored = routine_monitor_enable &&
      (!monitor_single_channel || convChannel_ff == monitor_channel_number);

   always_comb
   begin
      justified = {4'h0, rawResult};
      if (result_justify_select)
      begin
         case (resolutionSelect)
            adc_seq_pkg::RES_12: justified = {rawResult, 4'h0};
            adc_seq_pkg::RES_10: justified = {rawResult[9:0], 6'h00};
            adc_seq_pkg::RES_8: justified = {rawResult[7:0], 8'h00};
            default: justified = {8'h00, rawResult[5:0], 2'h0};
         endcase
      end
   end

   always_comb
   begin
      nxt_state = state_ff;
      nxt_seqIdx = seqIdx_ff;
      nxt_chunkLeft = chunkLeft_ff;
      nxt_cycCnt = cycCnt_ff;
      nxt_convChannel = convChannel_ff;
      nxt_resultData = resultData_ff;
      nxt_sequenceDone = sequenceDone_ff && !seqDoneClear;
      nxt_threshold = thrFlag_ff && !thresholdEventClear;
      case (state_ff)
         ST_IDLE:
         begin
            // a refused internal channel leaves every field untouched
            if (trigger && bufReady && chanAllowed)
            begin
               nxt_state = ST_SAMPLE;
               nxt_convChannel = curChan;
               nxt_cycCnt = 9'h000;
               nxt_chunkLeft = {1'b0, chunk_length_minus_one};
            end
         end
         ST_SAMPLE:
         begin
            nxt_cycCnt = cycCnt_ff + 9'h002;
            if (cycCnt_ff + 9'h002 >= smpHalf)
            begin
               nxt_state = ST_CONVERT;
               nxt_cycCnt = 9'h000;
            end
         end
         ST_CONVERT:
         begin
            nxt_cycCnt = cycCnt_ff + 9'h002;
            if (cycCnt_ff + 9'h002 >= 9'(adc_seq_pkg::CONV_HALF_CYCLES))
               nxt_state = ST_STORE;
         end
         ST_STORE:
         begin
            if (bufReady)
            begin
               nxt_resultData = justified;
               if (monitored && outOfWindow)
                  nxt_threshold = 1'b1;
               nxt_cycCnt = 9'h000;
               if (lastInSeq)
               begin
                  nxt_sequenceDone = 1'b1;
                  nxt_seqIdx = 4'h0;
                  nxt_state = ST_IDLE;
               end
               else
               begin
                  nxt_seqIdx = seqIdx_ff + 4'h1;
                  if ((chunked_mode_enable && chunkLeft_ff == 4'h0) ||
                      (!chunked_mode_enable && !scan_mode_enable))
                     nxt_state = ST_IDLE;
                  else
                  begin
                     nxt_state = ST_SAMPLE;
                     nxt_convChannel = sequence_list_regs[(seqIdx_ff + 4'h1)*5 +: 5];
                  end
                  nxt_chunkLeft = chunkLeft_ff - 4'h1;
               end
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
      nxt_sampling = (nxt_state == ST_SAMPLE);
      nxt_busy = (nxt_state != ST_IDLE);
      nxt_irq = (nxt_sequenceDone && sequence_done_irq_enable) ||
         (nxt_threshold && threshold_event_irq_enable);
   end

   assign bufValid = (state_ff == ST_STORE) && dmaEnable;

   adc_skid_buffer #(
      .WIDTH(16)
   ) u_buf (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .inValid(bufValid),
      .inReady(bufReady),
      .inData(justified),
      .outValid(dmaRequest),
      .outReady(dmaReady),
      .outData(dmaData)
   );

   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         state_ff <= ST_IDLE;
         seqIdx_ff <= 4'h0;
         chunkLeft_ff <= 4'h0;
         cycCnt_ff <= 9'h000;
         convChannel_ff <= 5'h00;
         resultData_ff <= adc_seq_pkg::RESULT_RESET;
         sequenceDone_ff <= 1'b0;
         thrFlag_ff <= 1'b0;
         irq_ff <= 1'b0;
         sampling_ff <= 1'b0;
         busy_ff <= 1'b0;
         trigPrev_ff <= 1'b0;
         tempSensorPowered_ff <= 1'b0;
         batteryDividerOn_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         seqIdx_ff <= nxt_seqIdx;
         chunkLeft_ff <= nxt_chunkLeft;
         cycCnt_ff <= nxt_cycCnt;
         convChannel_ff <= nxt_convChannel;
         resultData_ff <= nxt_resultData;
         sequenceDone_ff <= nxt_sequenceDone;
         thrFlag_ff <= nxt_threshold;
         irq_ff <= nxt_irq;
         sampling_ff <= nxt_sampling;
         busy_ff <= nxt_busy;
         trigPrev_ff <= trigSel;
         tempSensorPowered_ff <= temp_ref_channel_enable;
         batteryDividerOn_ff <= battery_channel_enable;
      end
   end

   a_done_only_last: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(sequenceDone_ff) |-> $past(state_ff) == ST_STORE && $past(lastInSeq))
      else $error("done flag set before sequence end");
   a_done_clear: assert property (@(posedge clk_sys) disable iff (!nrst)
      seqDoneClear && !(state_ff == ST_STORE && bufReady && lastInSeq) |=> !sequenceDone_ff)
      else $error("done flag not cleared");
   a_irq_gate: assert property (@(posedge clk_sys) disable iff (!nrst)
      irq_ff |-> $past(nxt_sequenceDone && sequence_done_irq_enable
      || nxt_threshold && threshold_event_irq_enable))
      else $error("irq without enabled source");
   a_chunk_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
      state_ff == ST_STORE && bufReady && chunked_mode_enable && chunkLeft_ff == 4'h0
      |=> state_ff == ST_IDLE)
      else $error("chunk overran length");
   a_restart_first: assert property (@(posedge clk_sys) disable iff (!nrst)
      state_ff == ST_STORE && bufReady && lastInSeq |=> seqIdx_ff == 4'h0)
      else $error("sequence did not restart");
   a_thr_event: assert property (@(posedge clk_sys) disable iff (!nrst)
      state_ff == ST_STORE && bufReady && monitored && outOfWindow |=> thrFlag_ff)
      else $error("threshold event missed");
   a_dma_per_conv: assert property (@(posedge clk_sys) disable iff (!nrst)
      state_ff == ST_STORE && bufReady && dmaEnable |=> dmaRequest)
      else $error("dma request missing");
   a_trig_start: assert property (@(posedge clk_sys) disable iff (!nrst)
      state_ff == ST_IDLE && trigger && bufReady && chanAllowed |=> sampling_ff)
      else $error("trigger did not start");

   sequence s_conv_entry;
      state_ff == ST_SAMPLE ##1 state_ff == ST_CONVERT;
   endsequence
   sequence s_conv_exit;
      state_ff == ST_CONVERT ##1 state_ff == ST_STORE;
   endsequence
   // 12.5 converter cycles rounded up to 13 clocks
   a_conv_length: assert property (@(posedge clk_sys) disable iff (!nrst)
      s_conv_entry |-> ##12 s_conv_exit)
      else $error("conversion length wrong");
endmodule : adc_routine_sequence_control
`default_nettype wire

/* File: adc_dma_sink_model.sv */
// dma side model that drains result words and can stall
`timescale 1ns/1ps
`default_nettype none
module adc_dma_sink_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic stall,
   input wire logic dmaRequest,
   input wire logic [15:0] dmaData,
   output logic dmaReady,
   output logic [15:0] lastWord_ff,
   output logic [15:0] wordCount_ff
);
   always_comb
   begin
      dmaReady = nrst && !stall;
   end
   always_ff @(posedge clk_sys)
   begin
      if (!nrst)
      begin
         wordCount_ff <= 16'h0000;
         lastWord_ff <= 16'h0000;
      end
      else if (dmaRequest && dmaReady)
      begin
         // one word taken per handshake
         wordCount_ff <= wordCount_ff + 16'h0001;
         lastWord_ff <= dmaData;
      end
   end
endmodule : adc_dma_sink_model
`default_nettype wire

/* File: adc_routine_sequence_control_tb_top.sv */
// testbench for the routine sequence controller with a stalling dma side
`timescale 1ns/1ps
`default_nettype none
module adc_routine_sequence_control_tb_top;
   logic clk_sys = 1'b0, nrst, converter_power_on, scan_mode_enable, chunked_mode_enable;
   logic external_trigger_enable, software_start_bit, routine_monitor_enable;
   logic monitor_single_channel, result_justify_select, dmaEnable, sequence_done_irq_enable;
   logic threshold_event_irq_enable, seqDoneClear, thresholdEventClear, temp_ref_channel_enable;
   logic battery_channel_enable, stall, dmaReady, sequenceDone_ff, threshold_event_flag, irq_ff;
   logic dmaRequest, sampling_ff, busy_ff, tempSensorPowered_ff, batteryDividerOn_ff;
   logic [2:0] chunk_length_minus_one, trigger_source_select;
   logic [3:0] sequenceLengthMinusOne;
   logic [79:0] sequence_list_regs;
   logic [56:0] sample_time_regs;
   logic [6:0] tmr;
   logic [4:0] monitor_channel_number, convChannel_ff;
   logic [11:0] upper_threshold, lower_threshold, rawResult;
   logic [1:0] resolutionSelect;
   logic [15:0] resultData_ff, dmaData, lastWord_ff, wordCount_ff;
   int miscompares = 0;
   int cmp_count = 0;
   always #(adc_seq_pkg::CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
   adc_routine_sequence_control DUT (.clk_sys, .nrst, .converter_power_on, .scan_mode_enable,
      .chunked_mode_enable, .chunk_length_minus_one, .sequenceLengthMinusOne,
      .sequence_list_regs, .sample_time_regs, .external_trigger_enable, .trigger_source_select,
      .software_start_bit, .timer_a_ch0_event(tmr[0]), .timer_a_ch1_event(tmr[1]),
      .timer_a_ch2_event(tmr[2]), .timer_b_ch1_event(tmr[3]), .timer_c_trigger_out(tmr[4]),
      .timer_d_ch0_event(tmr[5]), .ext_line_eleven(tmr[6]), .routine_monitor_enable,
      .monitor_single_channel, .monitor_channel_number, .upper_threshold, .lower_threshold,
      .result_justify_select, .resolutionSelect, .rawResult, .dmaEnable, .dmaReady,
      .sequence_done_irq_enable, .threshold_event_irq_enable, .seqDoneClear,
      .thresholdEventClear, .temp_ref_channel_enable, .battery_channel_enable, .sequenceDone_ff,
      .threshold_event_flag, .irq_ff, .resultData_ff, .dmaRequest, .dmaData, .convChannel_ff,
      .sampling_ff, .busy_ff, .tempSensorPowered_ff, .batteryDividerOn_ff);
   adc_dma_sink_model dmaSide (.clk_sys, .nrst, .stall, .dmaRequest, .dmaData, .dmaReady,
      .lastWord_ff, .wordCount_ff);
   task automatic tick();
      @(posedge clk_sys);
      #2;
   endtask : tick
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      if (miscompares == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   task automatic trig(input logic [2:0] code);
      if (code == adc_seq_pkg::SRC_SOFTWARE)
         software_start_bit = 1'b1;
      else
         tmr[code] = 1'b1;
      tick();
      software_start_bit = 1'b0;
      tmr = 7'h00;
   endtask : trig
   task automatic idle(output int n);
      n = 0;
      while (busy_ff !== 1'b0 && n < 4000)
      begin
         tick();
         n++;
      end
      // a conversion that never ends counts against the run
      if (n >= 4000)
         miscompares++;
      repeat (4) tick();
   endtask : idle
   task automatic chunk(input logic [15:0] words, input logic [4:0] ch, input logic done);
      int n;
      trig(adc_seq_pkg::SRC_SOFTWARE);
      check("sampling", 16'(sampling_ff), 16'h0001);
      idle(n);
      check("dma words", wordCount_ff, words);
      check("last channel", 16'(convChannel_ff), 16'(ch));
      check("sequence done", 16'(sequenceDone_ff), 16'(done));
   endtask : chunk
   task automatic clear_done();
      seqDoneClear = 1'b1;
      tick();
      seqDoneClear = 1'b0;
      tick();
      check("done cleared", 16'(sequenceDone_ff), 16'h0000);
   endtask : clear_done
   initial
   begin
      int n0;
      int n7;
      logic [5:0] thrExp;
      {nrst, scan_mode_enable, external_trigger_enable, software_start_bit,
         routine_monitor_enable, monitor_single_channel, result_justify_select,
         threshold_event_irq_enable, seqDoneClear, thresholdEventClear, temp_ref_channel_enable,
         battery_channel_enable, stall, tmr, monitor_channel_number, lower_threshold,
         resolutionSelect, sample_time_regs} = '0;
      for (int i = 0; i < 16; i++)
         sequence_list_regs[i*5+:5] = 5'(i + 1);
      {converter_power_on, chunked_mode_enable, dmaEnable, sequence_done_irq_enable} = 4'hf;
      chunk_length_minus_one = 3'h1;
      sequenceLengthMinusOne = 4'h4;
      trigger_source_select = adc_seq_pkg::SRC_SOFTWARE;
      upper_threshold = 12'hfff;
      rawResult = 12'h5a3;
      // expected event per monitor step: in, above, below, named, other, off
      thrExp = 6'h0e;
      repeat (5) tick();
      nrst = 1'b1;
      chunk(16'h0002, 5'h02, 1'b0);
      check("right justify", lastWord_ff, {4'h0, rawResult});
      chunk(16'h0004, 5'h04, 1'b0);
      chunk(16'h0005, 5'h05, 1'b1);
      check("done irq", 16'(irq_ff), 16'h0001);
      clear_done();
      chunk(16'h0007, 5'h02, 1'b0);
      chunk_length_minus_one = 3'h7;
      chunk(16'h000a, 5'h05, 1'b1);
      clear_done();
      sequenceLengthMinusOne = 4'h9;
      stall = 1'b1;
      trig(adc_seq_pkg::SRC_SOFTWARE);
      repeat (300) tick();
      check("stalled words", wordCount_ff, 16'h000a);
      stall = 1'b0;
      idle(n0);
      check("words after stall", wordCount_ff, 16'h0012);
      check("chunk of eight", 16'(convChannel_ff), 16'h0008);
      chunk(16'h0014, 5'h0a, 1'b1);
      clear_done();
      {chunked_mode_enable, sequence_done_irq_enable, result_justify_select} = 3'h1;
      sequenceLengthMinusOne = 4'h0;
      trig(adc_seq_pkg::SRC_SOFTWARE);
      idle(n0);
      check("left justify", lastWord_ff, {rawResult, 4'h0});
      check("stored result", resultData_ff, {rawResult, 4'h0});
      check("done single slot", 16'(sequenceDone_ff), 16'h0001);
      check("done irq masked", 16'(irq_ff), 16'h0000);
      // 1.5 and 12.5 cycles rounded up, plus the store clock
      check("conversion clocks", 16'(n0), 16'h0010);
      sample_time_regs[3+:3] = 3'h7;
      trig(adc_seq_pkg::SRC_SOFTWARE);
      idle(n7);
      // 239.5 against 1.5 sample cycles
      check("longer sample time", 16'(n7 - n0), 16'h00ee);
      resolutionSelect = adc_seq_pkg::RES_6;
      trig(adc_seq_pkg::SRC_SOFTWARE);
      idle(n0);
      check("byte justify", lastWord_ff, {8'h00, rawResult[5:0], 2'h0});
      resolutionSelect = adc_seq_pkg::RES_12;
      {routine_monitor_enable, threshold_event_irq_enable} = 2'h3;
      {upper_threshold, lower_threshold, rawResult} = {12'h500, 12'h100, 12'h300};
      for (int k = 0; k < 6; k++)
      begin
         case (k)
            1: rawResult = 12'h5a3;
            2: rawResult = 12'h0a0;
            3: {monitor_single_channel, monitor_channel_number, rawResult} = {6'h21, 12'h5a3};
            4: monitor_channel_number = 5'h02;
            5: {routine_monitor_enable, monitor_single_channel} = 2'h0;
            default: ;
         endcase
         trig(adc_seq_pkg::SRC_SOFTWARE);
         idle(n0);
         check("threshold event", 16'(threshold_event_flag), 16'(thrExp[k]));
         check("threshold irq", 16'(irq_ff), 16'(thrExp[k]));
         thresholdEventClear = 1'b1;
         tick();
         thresholdEventClear = 1'b0;
         tick();
      end
      check("event cleared", 16'(threshold_event_flag), 16'h0000);
      external_trigger_enable = 1'b1;
      for (int c = 0; c < 7; c++)
      begin
         trigger_source_select = 3'(c);
         trig((c == 0) ? adc_seq_pkg::SRC_SOFTWARE : 3'(c - 1));
         tick();
         check("other source idle", 16'(busy_ff), 16'h0000);
         trig(3'(c));
         check("selected source", 16'(busy_ff), 16'h0001);
         idle(n0);
      end
      trigger_source_select = adc_seq_pkg::SRC_SOFTWARE;
      sequence_list_regs[4:0] = adc_seq_pkg::CH_TEMP;
      trig(adc_seq_pkg::SRC_SOFTWARE);
      check("temp channel refused", 16'(busy_ff), 16'h0000);
      sequence_list_regs[4:0] = adc_seq_pkg::CH_BATT;
      tick();
      trig(adc_seq_pkg::SRC_SOFTWARE);
      check("battery channel refused", 16'(busy_ff), 16'h0000);
      tick();
      battery_channel_enable = 1'b1;
      temp_ref_channel_enable = 1'b1;
      trig(adc_seq_pkg::SRC_SOFTWARE);
      check("battery channel taken", 16'(busy_ff), 16'h0001);
      check("divider on", 16'(batteryDividerOn_ff), 16'h0001);
      check("sensor powered", 16'(tempSensorPowered_ff), 16'h0001);
      idle(n0);
      sequence_list_regs[4:0] = adc_seq_pkg::CH_VREF;
      trig(adc_seq_pkg::SRC_SOFTWARE);
      check("reference channel taken", 16'(busy_ff), 16'h0001);
      idle(n0);
      {battery_channel_enable, temp_ref_channel_enable} = 2'h0;
      repeat (2) tick();
      check("sensor down", 16'(tempSensorPowered_ff), 16'h0000);
      check("divider off", 16'(batteryDividerOn_ff), 16'h0000);
      finish_test();
   end
   initial
   begin
      #(adc_seq_pkg::CLK_PERIOD_NS * 80000);
      miscompares++;
      finish_test();
   end
endmodule : adc_routine_sequence_control_tb_top
`default_nettype wire
